//--- core/tmr_timer8.sv
`timescale 1ns/1ps
`include "tmr_params.svh"

// Functional notes
// R1: Three independent channels, each 8-bit counter, 8-bit compare, one output.
// R2: Run bit 7 low stops channel and holds counter at 00H.
// R3: Bit 6 selects timer/counter mode (0) or PWM mode (1).
// R4: Ch0 clock: clk, clk/8, event rising, event falling.
// R5: Ch1 clock: clk/16, clk/256, event rising, event falling.
// R6: Ch2 clock: clk/32, clk/128, subsystem clock; code 11 never counts.
// R7: Bit 0 set lets the timer drive the pin, else port latch.
// R8: Reset clears all mode registers to 00H.
// R9: Mode and direction registers take single-bit and whole-byte writes.
// R10: Software stops a channel before changing other mode bits.
// R11: Software masks the match interrupt before using PWM.
// R12: Software keeps buzzer output off when ch2 output is enabled.
// R13: Software clears direction bit and port latch to drive output.
// R14: Reset sets both direction registers to FFH.
// R15: Direction bit 0 drives the pin, 1 leaves it as input.
// R16: Only ch0 and ch1 count external events.
// R17: PWM mode gives 8-bit duty resolution on the output.
// R18: Timer match clears counter to 00H, keeps counting, pulses request.
// R19: With output enabled, each match toggles the output.
// R20: Stopping a channel forces its square-wave level to 0.
// R21: Event counter increments once per selected edge.
// R22: PWM counts freely over 256, output high while count below compare.
// R23: Compare registers are 8-bit read/write.
module tmr_timer8
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Processor access
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wmask,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // External clocks and event pins
  input wire logic ch0_event_in,
  input wire logic ch1_event_in,
  input wire logic sub_clk_in,
  // Port output latches of the shared pins
  input wire logic pin26_latch,
  input wire logic pin31_latch,
  input wire logic pin33_latch,
  // Shared pins
  output logic [2:0] timer_pin_o,
  output logic [2:0] timer_pin_oe,
  // Match requests
  output logic [2:0] channel_match_irq
);

  tmr_state_type st_reg;
  tmr_state_type st_next;
  logic [2:0] tick;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] match;
  logic [2:0] latch_in;

  assign latch_in = {pin33_latch, pin31_latch, pin26_latch};

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] data,
                                        input logic [7:0] mask);
    merge8 = (old & ~mask) | (data & mask);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.presc = st_reg.presc + 8'h01;
    st_next.irq = 3'h0;
    // Sync: only the second stage reads the first
    st_next.sync[0] = {st_reg.sync[0][1:0], ch0_event_in};
    st_next.sync[1] = {st_reg.sync[1][1:0], ch1_event_in};
    st_next.sync[2] = {st_reg.sync[2][1:0], sub_clk_in};
    for (int i = 0; i < 3; i++) begin
      rise[i] = st_reg.sync[i][1] & st_reg.sync[i][2] & ~st_reg.lvl[i];
      fall[i] = ~st_reg.sync[i][1] & ~st_reg.sync[i][2] & st_reg.lvl[i];
      if (st_reg.sync[i][1] == st_reg.sync[i][2]) begin
        st_next.lvl[i] = st_reg.sync[i][2];
      end
    end
    // Clock selection per channel
    unique case (st_reg.mode[0].sel) // see R4
      TMR_SEL_A: tick[0] = 1'b1;
      TMR_SEL_B: tick[0] = (st_reg.presc & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
      TMR_SEL_C: tick[0] = rise[0]; // see R16
      TMR_SEL_D: tick[0] = fall[0];
    endcase
    unique case (st_reg.mode[1].sel) // see R5
      TMR_SEL_A: tick[1] = (st_reg.presc & `TMR_DIV16_MASK) == `TMR_DIV16_MASK;
      TMR_SEL_B: tick[1] = st_reg.presc == `TMR_DIV256_MASK;
      TMR_SEL_C: tick[1] = rise[1];
      TMR_SEL_D: tick[1] = fall[1];
    endcase
    unique case (st_reg.mode[2].sel) // see R6
      TMR_SEL_A: tick[2] = (st_reg.presc & `TMR_DIV32_MASK) == `TMR_DIV32_MASK;
      TMR_SEL_B:
        tick[2] = (st_reg.presc & `TMR_DIV128_MASK) == `TMR_DIV128_MASK;
      TMR_SEL_C: tick[2] = rise[2];
      TMR_SEL_D: tick[2] = 1'b0;
    endcase
    // Register writes; mode and direction writes bit-masked so single-bit writes work
    if (bus_wr) begin // see R9
      unique case (bus_addr)
        `TMR_ADDR_PDIR2:
          st_next.pdir2 = merge8(st_reg.pdir2, bus_wdata, bus_wmask)
                          | `TMR_PDIR2_FIX1;
        `TMR_ADDR_PDIR3:
          st_next.pdir3 = merge8(st_reg.pdir3, bus_wdata, bus_wmask)
                          | `TMR_PDIR3_FIX1;
        `TMR_ADDR_MODE0:
          st_next.mode[0] = merge8(st_reg.mode[0], bus_wdata,
                                   bus_wmask) & `TMR_MODE_WMASK;
        `TMR_ADDR_MODE1:
          st_next.mode[1] = merge8(st_reg.mode[1], bus_wdata,
                                   bus_wmask) & `TMR_MODE_WMASK;
        `TMR_ADDR_MODE2:
          st_next.mode[2] = merge8(st_reg.mode[2], bus_wdata,
                                   bus_wmask) & `TMR_MODE_WMASK;
        `TMR_ADDR_CMP0: st_next.cmp[0] = bus_wdata; // see R23
        `TMR_ADDR_CMP1: st_next.cmp[1] = bus_wdata;
        `TMR_ADDR_CMP2: st_next.cmp[2] = bus_wdata;
        default: ;
      endcase
    end
    // Channels; counting follows the mode held before this write
    for (int i = 0; i < 3; i++) begin // see R1
      match[i] = st_reg.cnt[i] == st_reg.cmp[i];
      if (!st_reg.mode[i].run) begin
        st_next.cnt[i] = 8'h00; // see R2
        st_next.tout[i] = 1'b0; // see R20
      end else if (st_reg.mode[i].pwm) begin // see R3
        if (tick[i]) begin
          st_next.cnt[i] = st_reg.cnt[i] + 8'h01; // see R22
        end
        st_next.tout[i] = st_next.cnt[i] < st_next.cmp[i]; // see R17
      end else if (tick[i]) begin
        if (match[i]) begin
          st_next.cnt[i] = 8'h00; // see R18
          st_next.irq[i] = 1'b1;
          if (st_reg.mode[i].toe) begin
            st_next.tout[i] = ~st_reg.tout[i]; // see R19
          end
        end else begin
          st_next.cnt[i] = st_reg.cnt[i] + 8'h01; // see R21
        end
      end
      // Pin mux; latch is ignored while the timer drives the pin
      st_next.pin_o[i] = st_next.mode[i].toe ? st_next.tout[i]
                                             : latch_in[i]; // see R7
    end
    st_next.pin_oe[0] = ~st_next.pdir2[`TMR_PIN26_BIT]; // see R15
    st_next.pin_oe[1] = ~st_next.pdir3[`TMR_PIN31_BIT];
    st_next.pin_oe[2] = ~st_next.pdir3[`TMR_PIN33_BIT];
    // Read data, one cycle after the strobe
    if (bus_rd) begin
      unique case (bus_addr)
        `TMR_ADDR_PDIR2: st_next.rdata = st_reg.pdir2;
        `TMR_ADDR_PDIR3: st_next.rdata = st_reg.pdir3;
        `TMR_ADDR_MODE0: st_next.rdata = st_reg.mode[0];
        `TMR_ADDR_MODE1: st_next.rdata = st_reg.mode[1];
        `TMR_ADDR_MODE2: st_next.rdata = st_reg.mode[2];
        `TMR_ADDR_CNT0: st_next.rdata = st_reg.cnt[0];
        `TMR_ADDR_CMP0: st_next.rdata = st_reg.cmp[0];
        `TMR_ADDR_CNT1: st_next.rdata = st_reg.cnt[1];
        `TMR_ADDR_CMP1: st_next.rdata = st_reg.cmp[1];
        `TMR_ADDR_CNT2: st_next.rdata = st_reg.cnt[2];
        `TMR_ADDR_CMP2: st_next.rdata = st_reg.cmp[2];
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0; // see R8
      st_reg.pdir2 <= `TMR_RST_PDIR; // see R14
      st_reg.pdir3 <= `TMR_RST_PDIR;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign timer_pin_o = st_reg.pin_o;
  assign timer_pin_oe = st_reg.pin_oe;
  assign channel_match_irq = st_reg.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence match_step_s(int i);
    st_reg.mode[i].run && !st_reg.mode[i].pwm && tick[i] && match[i];
  endsequence

  for (genvar g = 0; g < 3; g++) begin : g_chk
    stop_clear_a: assert property ( // see R2
      !st_reg.mode[g].run |=> st_reg.cnt[g] == 8'h00)
      else $error("stopped counter not cleared");
    stop_low_a: assert property ( // see R20
      !st_reg.mode[g].run |=> !st_reg.tout[g])
      else $error("stopped output not low");
    match_wrap_a: assert property ( // see R18
      match_step_s(g) |=> st_reg.cnt[g] == 8'h00 && channel_match_irq[g])
      else $error("match did not clear and request");
    match_toggle_a: assert property ( // see R19
      match_step_s(g) ##0 st_reg.mode[g].toe |=>
        st_reg.tout[g] != $past(st_reg.tout[g]))
      else $error("match did not toggle output");
    count_step_a: assert property ( // see R21
      st_reg.mode[g].run && !st_reg.mode[g].pwm && tick[g] && !match[g]
      |=> st_reg.cnt[g] == $past(st_reg.cnt[g]) + 8'h01)
      else $error("counter did not step by one");
    pwm_duty_a: assert property ( // see R22
      st_reg.mode[g].run && st_reg.mode[g].pwm && $stable(st_reg.mode[g])
      |-> st_reg.tout[g] == (st_reg.cnt[g] < st_reg.cmp[g]))
      else $error("pwm level wrong");
    pin_drive_a: assert property ( // see R7
      st_reg.mode[g].toe |-> timer_pin_o[g] == st_reg.tout[g])
      else $error("pin not driven by timer");
  end

  ch2_forbid_a: assert property ( // see R6
    st_reg.mode[2].sel == TMR_SEL_D |-> !tick[2])
    else $error("prohibited ch2 clock counted");
  div8_tick_a: assert property ( // see R4
    st_reg.mode[0].sel == TMR_SEL_B |->
      tick[0] == (st_reg.presc[2:0] == 3'h7))
    else $error("ch0 divide by 8 wrong");
  dir_oe_a: assert property ( // see R15
    1'b1 |=> timer_pin_oe[0] == !st_reg.pdir2[`TMR_PIN26_BIT])
    else $error("pin26 enable wrong");

endmodule

//--- core/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TMR_ADDR_PDIR2 16'hff22
`define TMR_ADDR_PDIR3 16'hff23
`define TMR_ADDR_MODE0 16'hff53
`define TMR_ADDR_MODE1 16'hff57
`define TMR_ADDR_MODE2 16'hff5b
`define TMR_ADDR_CNT0 16'hff50
`define TMR_ADDR_CMP0 16'hff51
`define TMR_ADDR_CNT1 16'hff54
`define TMR_ADDR_CMP1 16'hff55
`define TMR_ADDR_CNT2 16'hff58
`define TMR_ADDR_CMP2 16'hff59

// ----------------------------------------
// Reset values and fixed bits
// ----------------------------------------
`define TMR_RST_MODE 8'h00
`define TMR_RST_PDIR 8'hff
`define TMR_MODE_WMASK 8'hc7
`define TMR_PDIR2_FIX1 8'h80
`define TMR_PDIR3_FIX1 8'hf0

// ----------------------------------------
// Pin positions inside the direction registers
// ----------------------------------------
`define TMR_PIN26_BIT 6
`define TMR_PIN31_BIT 1
`define TMR_PIN33_BIT 3

// ----------------------------------------
// Prescaler tick masks (divide by 2^k)
// ----------------------------------------
`define TMR_DIV8_MASK 8'h07
`define TMR_DIV16_MASK 8'h0f
`define TMR_DIV32_MASK 8'h1f
`define TMR_DIV128_MASK 8'h7f
`define TMR_DIV256_MASK 8'hff

`endif

//--- core/tmr_pkg.sv
package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_SEL_A = 2'h0,
    TMR_SEL_B = 2'h1,
    TMR_SEL_C = 2'h2,
    TMR_SEL_D = 2'h3
  } tmr_sel_type;

  typedef struct packed {
    logic run;
    logic pwm;
    logic [2:0] rsv;
    tmr_sel_type sel;
    logic toe;
  } tmr_mode_type;

  typedef struct packed {
    tmr_mode_type [2:0] mode;
    logic [2:0][7:0] cmp;
    logic [2:0][7:0] cnt;
    logic [2:0] tout;
    logic [7:0] pdir2;
    logic [7:0] pdir3;
    logic [7:0] presc;
    logic [2:0][2:0] sync;
    logic [2:0] lvl;
    logic [2:0] irq;
    logic [7:0] rdata;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
  } tmr_state_type;

endpackage

//--- verification/tmr_event_model.sv
`timescale 1ns/1ps
module tmr_event_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Edge requests
  input wire logic [2:0] toggle_req,
  // Pins
  output logic ch0_event_in,
  output logic ch1_event_in,
  output logic sub_clk_in
);
  // Pins move only on request, so edges stay well apart
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch0_event_in <= 1'b0;
      ch1_event_in <= 1'b0;
      sub_clk_in <= 1'b0;
    end else begin
      ch0_event_in <= ch0_event_in ^ toggle_req[0];
      ch1_event_in <= ch1_event_in ^ toggle_req[1];
      sub_clk_in <= sub_clk_in ^ toggle_req[2];
    end
  end
endmodule

//--- verification/tb_triple_8bit_timer_event_counter.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
module tb_triple_8bit_timer_event_counter;
  import tmr_pkg::*;
  logic clk_sys, arst_n, bus_wr, bus_rd, rd_d, e0, e1, sc, p;
  logic [15:0] bus_addr, b;
  logic [7:0] bus_wmask, bus_wdata, bus_rdata;
  logic [2:0] latch, tog, pin_o, pin_oe, irq;
  logic [7:0] exp_q[$];
  logic [31:0] lf;
  int err_total, checked, n, hi, ch;
  int tc[6] = '{0, 0, 1, 1, 2, 2};
  int tp[6] = '{3, 24, 32, 256, 32, 128};
  int tm[6] = '{2, 2, 1, 0, 0, 0};
  int ev[6] = '{2, 2, 2, 2, 2, 0};

  tmr_event_model i_model (.clk_sys(clk_sys), .arst_n(arst_n),
    .toggle_req(tog), .ch0_event_in(e0), .ch1_event_in(e1),
    .sub_clk_in(sc));
  tmr_timer8 i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wmask(bus_wmask),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ch0_event_in(e0), .ch1_event_in(e1), .sub_clk_in(sc),
    .pin26_latch(latch[0]), .pin31_latch(latch[1]),
    .pin33_latch(latch[2]), .timer_pin_o(pin_o),
    .timer_pin_oe(pin_oe), .channel_match_irq(irq));

  // ----------------
  // Helpers
  // ----------------
  function automatic logic [7:0] mb(logic r, logic w, int s, logic t);
    tmr_mode_type m;
    m = '{run: r, pwm: w, rsv: 3'h0, sel: tmr_sel_type'(s), toe: t};
    return 8'(m);
  endfunction
  function automatic logic [31:0] lfsr_step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] e);
    checked++;
    if (seen !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d, logic [7:0] m);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus_rd <= 1'b0;
  endtask
  task automatic wait_irq(int c, int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (irq[c] !== 1'b1 && n < lim);
    if (irq[c] !== 1'b1) begin
      check("irq wait", irq[c], 1'b1);
      wrap_up();
    end
  endtask

  // Read data lands one cycle after the strobe
  always @(posedge clk_sys) rd_d <= bus_rd;
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      check("read data", bus_rdata, exp_q.pop_front());
    end
  end

  // ----------------
  // Sequence
  // ----------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {arst_n, bus_wr, bus_rd, bus_addr, bus_wmask, bus_wdata} = '0;
    latch = '0;
    tog = '0;
    lf = 32'h268e304d;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int c = 0; c < 3; c++) rd(16'hff53 + 16'(4 * c), 8'h00);
    rd(`TMR_ADDR_PDIR2, 8'hff);
    rd(`TMR_ADDR_PDIR3, 8'hff);
    rd(16'hff00, 8'h00);
    @(negedge clk_sys);
    check("oe after reset", pin_oe, 3'h0);
    wr(`TMR_ADDR_MODE0, 8'h7f, 8'hff);
    rd(`TMR_ADDR_MODE0, 8'h47);
    wr(`TMR_ADDR_MODE0, 8'h00, 8'hff);
    for (int c = 0; c < 3; c++) begin
      lf = lfsr_step(lf);
      wr(16'hff51 + 16'(4 * c), lf[7:0], 8'hff);
      rd(16'hff51 + 16'(4 * c), lf[7:0]);
    end
    @(posedge clk_sys);
    latch <= lf[10:8];
    repeat (3) @(negedge clk_sys);
    check("port level", pin_o, lf[10:8]);
    @(posedge clk_sys);
    latch <= 3'h0;
    wr(`TMR_ADDR_PDIR2, 8'h00, 8'hff);
    rd(`TMR_ADDR_PDIR2, 8'h80);
    wr(`TMR_ADDR_PDIR3, 8'h00, 8'h02);
    wr(`TMR_ADDR_PDIR3, 8'h00, 8'h08);
    rd(`TMR_ADDR_PDIR3, 8'hf5);
    repeat (2) @(negedge clk_sys);
    check("oe", pin_oe, 3'h7);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      ch = tc[i];
      b = 16'hff50 + 16'(4 * ch);
      // Buzzer enable sits outside the block and stays off here
      wr(b + 16'h3, mb(0, 0, i % 2, 1), 8'hff);
      wr(b + 16'h1, 8'(tm[i]), 8'hff);
      wr(b + 16'h3, 8'h80, 8'h80);
      wait_irq(ch, 600);
      p = pin_o[ch];
      wait_irq(ch, 600);
      check("period", 16'(n), 16'(tp[i]));
      check("toggle", pin_o[ch], !p);
      wr(b + 16'h3, 8'h00, 8'h80);
      repeat (2) @(negedge clk_sys);
      check("stop level", pin_o[ch], 1'b0);
      rd(b, 8'h00);
      wr(b + 16'h3, mb(0, 0, 2 + i % 2, 0), 8'hff);
      wr(b + 16'h1, 8'hff, 8'hff);
      wr(b + 16'h3, 8'h80, 8'h80);
      repeat (4) begin
        @(posedge clk_sys);
        tog <= 3'(1 << ch);
        @(posedge clk_sys);
        tog <= 3'h0;
        repeat (8) @(posedge clk_sys);
      end
      rd(b, 8'(ev[i]));
      wr(b + 16'h3, 8'h00, 8'hff);
    end
    $display("timer and event done");
    // Match request of PWM mode is taken as masked
    wr(`TMR_ADDR_MODE0, 8'h41, 8'hff);
    wr(`TMR_ADDR_CMP0, 8'h40, 8'hff);
    wr(`TMR_ADDR_MODE0, 8'h80, 8'h80);
    repeat (20) @(negedge clk_sys);
    {hi, p} = '0;
    repeat (256) begin
      @(negedge clk_sys);
      hi += int'(pin_o[0]);
      p |= irq[0];
    end
    check("pwm high", 16'(hi), 16'h40);
    check("pwm irq", p, 1'b0);
    $display("pwm done");
    wrap_up();
  end
endmodule
